// ==== include/apd_pkg.sv ====
// Register map, field layout and codes of the auto-power-down control block.
package apd_pkg;
  localparam int APD_IDX_W = 10;
  localparam int APD_ADDR_W = 12;
  localparam int APD_N_PIN = 4;
  localparam int APD_N_CONV = 4;
  localparam int APD_N_ALARM = 5;
  localparam int APD_N_IRQ = 3;
  // ---------------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ---------------------------------------------------------------------
  localparam logic [9:0] APD_IDX_CLAMP = 10'h042;
  localparam logic [9:0] APD_IDX_REACT = 10'h043;
  localparam logic [9:0] APD_IDX_SRC = 10'h044;
  localparam logic [9:0] APD_IDX_IRQ_STAT = 10'h070;
  localparam logic [9:0] APD_IDX_IRQ_EN = 10'h071;
  localparam logic [9:0] APD_IDX_IRQ_CLR = 10'h072;
  localparam logic [9:0] APD_IDX_STATE = 10'h073;
  // ---------------------------------------------------------------------
  // Reset values and writable masks.
  // ---------------------------------------------------------------------
  localparam logic [15:0] APD_REACT_RST = 16'hAAFF;
  localparam logic [15:0] APD_SRC_RST = 16'h0000;
  localparam logic [15:0] APD_SRC_MASK = 16'h0133;
  localparam logic [15:0] APD_CLAMP_RST = 16'h0000;
  localparam logic [15:0] APD_CLAMP_MASK = 16'h000F;
  localparam logic [15:0] APD_ALL_MASK = 16'hFFFF;
  localparam logic [2:0] APD_IRQ_RST = 3'h0;
  // ---------------------------------------------------------------------
  // Field positions. Pin k: 0 = A0, 1 = A2, 2 = B0, 3 = B2.
  // ---------------------------------------------------------------------
  localparam int APD_PIN_LSB = 8;
  localparam int APD_CONV_A_LSB = 0;
  localparam int APD_CONV_B_LSB = 4;
  localparam int APD_SRC_TEMP = 8;
  localparam int APD_SRC_CONV1 = 5;
  localparam int APD_SRC_CONV0 = 4;
  localparam int APD_SRC_SENSE1 = 1;
  localparam int APD_SRC_SENSE0 = 0;
  localparam int APD_ALM_SENSE0 = 0;
  localparam int APD_ALM_SENSE1 = 1;
  localparam int APD_ALM_CONV0 = 2;
  localparam int APD_ALM_CONV1 = 3;
  localparam int APD_ALM_TEMP = 4;
  localparam int APD_IRQ_CONV_A = 0;
  localparam int APD_IRQ_GRP_B = 1;
  localparam int APD_IRQ_PIN_A = 2;
  localparam int APD_ST_EV_A = 8;
  // ---------------------------------------------------------------------
  // Pin reaction codes and bus responses.
  // ---------------------------------------------------------------------
  localparam logic [1:0] APD_CODE_IGNORE = 2'h0;
  localparam logic [1:0] APD_CODE_RAIL = 2'h2;
  localparam logic [1:0] APD_CODE_CLAMP = 2'h3;
  localparam logic [1:0] APD_RESP_OKAY = 2'h0;
  localparam logic [1:0] APD_RESP_SLVERR = 2'h2;
endpackage

// ==== logic/apd_axil_slave.sv ====
// AXI4-Lite slave front end with one write and one read under way.
`timescale 1ns/1ps
module apd_axil_slave
  import apd_pkg::*;
#(
  parameter int ADDR_W = APD_ADDR_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic wr_req_o,
  output logic [ADDR_W-3:0] wr_idx_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_ok_i,
  output logic rd_req_o,
  output logic [ADDR_W-3:0] rd_idx_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_ok_i
);
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] awaddr_q;

  assign awready_o = !aw_held && !bvalid_o;
  assign wready_o = !w_held && !bvalid_o;
  assign wr_req_o = aw_held && w_held && !bvalid_o;
  assign wr_idx_o = awaddr_q[ADDR_W-1:2];
  assign arready_o = !rvalid_o;
  assign rd_req_o = arvalid_i && !rvalid_o;
  assign rd_idx_o = araddr_i[ADDR_W-1:2];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= '0;
      wr_data_o <= '0;
      wr_strb_o <= '0;
      bvalid_o <= 1'b0;
      bresp_o <= APD_RESP_OKAY;
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      rresp_o <= APD_RESP_OKAY;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_held <= 1'b1;
        awaddr_q <= awaddr_i;
      end else if (wr_req_o) begin
        aw_held <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_held <= 1'b1;
        wr_data_o <= wdata_i;
        wr_strb_o <= wstrb_i;
      end else if (wr_req_o) begin
        w_held <= 1'b0;
      end
      if (wr_req_o) begin
        bvalid_o <= 1'b1;
        bresp_o <= wr_ok_i ? APD_RESP_OKAY : APD_RESP_SLVERR;
      end else if (bready_i) begin
        bvalid_o <= 1'b0;
      end
      if (rd_req_o) begin
        rvalid_o <= 1'b1;
        rdata_o <= rd_data_i;
        rresp_o <= rd_ok_i ? APD_RESP_OKAY : APD_RESP_SLVERR;
      end else if (rready_i) begin
        rvalid_o <= 1'b0;
      end
    end
  end

  bvalid_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped before it was taken");
  rvalid_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data dropped before it was taken");
endmodule

// ==== logic/apd_pin_react.sv ====
// Reaction of one output pin to an auto-power-down event.
`timescale 1ns/1ps
module apd_pin_react
  import apd_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] code_i,
  input wire logic clamp_sel_i,
  input wire logic event_i,
  output logic drive_off_o,
  output logic tie_rail_o,
  output logic tie_conv_o
);
  logic to_rail;
  logic to_clamp;
  logic next_drive_off;

  assign to_rail = event_i && code_i == APD_CODE_RAIL;
  assign to_clamp = event_i && code_i == APD_CODE_CLAMP;
  // Code 00 and the undefined code 01 both leave the pin alone.
  assign next_drive_off = to_rail || to_clamp;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      drive_off_o <= 1'b0;
      tie_rail_o <= 1'b0;
      tie_conv_o <= 1'b0;
    end else begin
      drive_off_o <= next_drive_off;
      tie_rail_o <= to_rail || (to_clamp && !clamp_sel_i);
      tie_conv_o <= to_clamp && clamp_sel_i;
    end
  end

  pin_ignore_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    code_i == APD_CODE_IGNORE |=> !drive_off_o && !tie_rail_o && !tie_conv_o)
    else $error("ignored pin reacted to an event");
  pin_rail_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    event_i && code_i == APD_CODE_RAIL |=> drive_off_o && tie_rail_o
      && !tie_conv_o)
    else $error("pin not tied to the rail");
  pin_clamp_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    event_i && code_i == APD_CODE_CLAMP |=> drive_off_o
      && (tie_conv_o == $past(clamp_sel_i)) && (tie_rail_o != tie_conv_o))
    else $error("pin clamp target wrong");
  pin_release_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    !event_i |=> !drive_off_o && !tie_rail_o && !tie_conv_o)
    else $error("pin held without an event");
  pin_conv_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    to_clamp && clamp_sel_i ##1 tie_conv_o);
endmodule

// ==== logic/apd_ctrl.sv ====
// Auto-power-down reaction and alarm-source control with register bank.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// Summary of operation
// - Pin code 00 leaves the group-B pin untouched by events.
// - Pin code 10 disables group-B drive and ties pin to rail.
// - Pin code 11 disables drive, ties to rail or converter per clamp.
// - Group-A pins react to codes 00, 10, 11 in the same way.
// - Pin fields sit at bits 15:8, B2, B0, A2, A0; each resets 2h.
// - Bits 7:4 enable B converters, 3:0 A converters; reset 1h each.
// - A converter with its enable cleared ignores events.
// - Alarms power down a group-A converter only if it is enabled.
// - Source bit 8 lets the temperature alarm raise the A event.
// - Source bits 5 and 4 gate converter-input alarms 1 and 0.
// - Source bits 1 and 0 gate current-sense alarms 1 and 0.
// - Alarm-source register at 44h resets to zero.
// - Clamp bit 0 picks the rail, 1 picks the neighbour converter.
module apd_ctrl
  import apd_pkg::*;
#(
  parameter int ADDR_W = APD_ADDR_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [APD_N_ALARM-1:0] alarm_i,
  input wire logic grp_b_event_i,
  input wire logic pin_a_event_i,
  output logic [APD_N_CONV-1:0] conv_a_pd_o,
  output logic [APD_N_CONV-1:0] conv_b_pd_o,
  output logic [APD_N_PIN-1:0] pin_drive_off_o,
  output logic [APD_N_PIN-1:0] pin_tie_rail_o,
  output logic [APD_N_PIN-1:0] pin_tie_conv_o,
  output logic irq_o
);
  // -----------------------------------------------------------------------
  // Decoding shared by reads and writes.
  // -----------------------------------------------------------------------
  function automatic logic apd_mapped(input logic [APD_IDX_W-1:0] idx);
    return idx == APD_IDX_CLAMP || idx == APD_IDX_REACT
      || idx == APD_IDX_SRC || idx == APD_IDX_IRQ_STAT
      || idx == APD_IDX_IRQ_EN || idx == APD_IDX_IRQ_CLR
      || idx == APD_IDX_STATE;
  endfunction

  function automatic logic [15:0] apd_merge(input logic [15:0] old,
    input logic [31:0] data, input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] val;
    val = old;
    if (strb[0]) begin
      val[7:0] = data[7:0];
    end
    if (strb[1]) begin
      val[15:8] = data[15:8];
    end
    return val & mask;
  endfunction

  // -----------------------------------------------------------------------
  // Bus slave.
  // -----------------------------------------------------------------------
  logic wr_req;
  logic [APD_IDX_W-1:0] wr_idx;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_req;
  logic [APD_IDX_W-1:0] rd_idx;
  logic [31:0] rd_data;
  logic wr_ok;
  logic rd_ok;

  apd_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .awaddr_i(s_axi_awaddr_i),
    .awvalid_i(s_axi_awvalid_i),
    .awready_o(s_axi_awready_o),
    .wdata_i(s_axi_wdata_i),
    .wstrb_i(s_axi_wstrb_i),
    .wvalid_i(s_axi_wvalid_i),
    .wready_o(s_axi_wready_o),
    .bresp_o(s_axi_bresp_o),
    .bvalid_o(s_axi_bvalid_o),
    .bready_i(s_axi_bready_i),
    .araddr_i(s_axi_araddr_i),
    .arvalid_i(s_axi_arvalid_i),
    .arready_o(s_axi_arready_o),
    .rdata_o(s_axi_rdata_o),
    .rresp_o(s_axi_rresp_o),
    .rvalid_o(s_axi_rvalid_o),
    .rready_i(s_axi_rready_i),
    .wr_req_o(wr_req),
    .wr_idx_o(wr_idx),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_ok_i(wr_ok),
    .rd_req_o(rd_req),
    .rd_idx_o(rd_idx),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  // -----------------------------------------------------------------------
  // Register bank.
  // -----------------------------------------------------------------------
  logic [15:0] clamp_q;
  logic [15:0] react_q;
  logic [15:0] src_q;
  logic [APD_N_IRQ-1:0] irq_stat;
  logic [APD_N_IRQ-1:0] irq_en;
  logic wr_clamp;
  logic wr_react;
  logic wr_src;
  logic wr_irq_en;
  logic [APD_N_IRQ-1:0] irq_clr;
  logic [15:0] state_word;
  logic [APD_N_ALARM-1:0] alarm_sel;
  logic conv_a_event;
  logic [APD_N_CONV-1:0] conv_a_en;
  logic [APD_N_CONV-1:0] conv_b_en;

  assign wr_ok = apd_mapped(wr_idx);
  assign rd_ok = apd_mapped(rd_idx);
  assign wr_clamp = wr_req && wr_idx == APD_IDX_CLAMP;
  assign wr_react = wr_req && wr_idx == APD_IDX_REACT;
  assign wr_src = wr_req && wr_idx == APD_IDX_SRC;
  assign wr_irq_en = wr_req && wr_idx == APD_IDX_IRQ_EN && wr_strb[0];
  assign irq_clr = (wr_req && wr_idx == APD_IDX_IRQ_CLR && wr_strb[0])
    ? wr_data[APD_N_IRQ-1:0] : '0;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      clamp_q <= APD_CLAMP_RST;
      react_q <= APD_REACT_RST;
      src_q <= APD_SRC_RST;
      irq_en <= APD_IRQ_RST;
    end else begin
      if (wr_clamp) begin
        clamp_q <= apd_merge(clamp_q, wr_data, wr_strb, APD_CLAMP_MASK);
      end
      if (wr_react) begin
        react_q <= apd_merge(react_q, wr_data, wr_strb, APD_ALL_MASK);
      end
      if (wr_src) begin
        src_q <= apd_merge(src_q, wr_data, wr_strb, APD_SRC_MASK);
      end
      if (wr_irq_en) begin
        irq_en <= wr_data[APD_N_IRQ-1:0];
      end
    end
  end

  assign state_word = {7'h00, conv_a_event, conv_b_pd_o, conv_a_pd_o};
  assign rd_data = rd_idx == APD_IDX_CLAMP ? {16'h0000, clamp_q}
    : rd_idx == APD_IDX_REACT ? {16'h0000, react_q}
    : rd_idx == APD_IDX_SRC ? {16'h0000, src_q}
    : rd_idx == APD_IDX_IRQ_STAT ? {29'h0000000, irq_stat}
    : rd_idx == APD_IDX_IRQ_EN ? {29'h0000000, irq_en}
    : rd_idx == APD_IDX_STATE ? {16'h0000, state_word}
    : 32'h00000000;

  // -----------------------------------------------------------------------
  // Group-A converter event and converter power-down.
  // -----------------------------------------------------------------------
  assign alarm_sel[APD_ALM_TEMP] = src_q[APD_SRC_TEMP];
  assign alarm_sel[APD_ALM_CONV1] = src_q[APD_SRC_CONV1];
  assign alarm_sel[APD_ALM_CONV0] = src_q[APD_SRC_CONV0];
  assign alarm_sel[APD_ALM_SENSE1] = src_q[APD_SRC_SENSE1];
  assign alarm_sel[APD_ALM_SENSE0] = src_q[APD_SRC_SENSE0];
  assign conv_a_event = |(alarm_i & alarm_sel);
  assign conv_a_en = react_q[APD_CONV_A_LSB +: APD_N_CONV];
  assign conv_b_en = react_q[APD_CONV_B_LSB +: APD_N_CONV];

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      conv_a_pd_o <= '0;
      conv_b_pd_o <= '0;
    end else begin
      conv_a_pd_o <= conv_a_en & {APD_N_CONV{conv_a_event}};
      conv_b_pd_o <= conv_b_en & {APD_N_CONV{grp_b_event_i}};
    end
  end

  // -----------------------------------------------------------------------
  // Output pin reactions.
  // -----------------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < APD_N_PIN; k++) begin : g_pin
      apd_pin_react u_pin (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .code_i(react_q[APD_PIN_LSB + 2 * k +: 2]),
        .clamp_sel_i(clamp_q[k]),
        .event_i(k < APD_N_PIN / 2 ? pin_a_event_i : grp_b_event_i),
        .drive_off_o(pin_drive_off_o[k]),
        .tie_rail_o(pin_tie_rail_o[k]),
        .tie_conv_o(pin_tie_conv_o[k])
      );
    end
  endgenerate

  // -----------------------------------------------------------------------
  // Interrupts on the rising edge of each event.
  // -----------------------------------------------------------------------
  logic [APD_N_IRQ-1:0] ev_now;
  logic [APD_N_IRQ-1:0] ev_prev;
  logic [APD_N_IRQ-1:0] ev_rise;

  assign ev_now = {pin_a_event_i, grp_b_event_i, conv_a_event};
  assign ev_rise = ev_now & ~ev_prev;
  assign irq_o = |(irq_stat & irq_en);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ev_prev <= APD_IRQ_RST;
      irq_stat <= APD_IRQ_RST;
    end else begin
      ev_prev <= ev_now;
      // A new event wins over a clear in the same cycle.
      irq_stat <= (irq_stat & ~irq_clr) | ev_rise;
    end
  end

  // -----------------------------------------------------------------------
  // Checks.
  // -----------------------------------------------------------------------
  react_reset_a: assert property (
    @(posedge sys_clk_i) $rose(rst_n_i) |-> react_q == APD_REACT_RST)
    else $error("reaction register reset value wrong");
  conv_en_reset_a: assert property (
    @(posedge sys_clk_i) $rose(rst_n_i) |-> conv_a_en == '1
      && conv_b_en == '1)
    else $error("converter enables not set after reset");
  src_reset_a: assert property (
    @(posedge sys_clk_i) $rose(rst_n_i) ##0 !wr_src [*2]
      |-> src_q == APD_SRC_RST)
    else $error("alarm source register not clear after reset");
  conv_gate_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    1'b1 |=> (conv_a_pd_o & ~$past(conv_a_en)) == '0
      && (conv_b_pd_o & ~$past(conv_b_en)) == '0)
    else $error("disabled converter powered down");
  temp_alarm_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    alarm_i[APD_ALM_TEMP] && src_q[APD_SRC_TEMP] && conv_a_en[0]
      |=> conv_a_pd_o[0])
    else $error("temperature alarm did not power down");
  conv_alarm_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    alarm_i[APD_ALM_CONV1] && src_q[APD_SRC_CONV1] |=> conv_a_pd_o
      == $past(conv_a_en))
    else $error("converter input alarm did not power down");
  sense_alarm_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    alarm_i[APD_ALM_SENSE0] && src_q[APD_SRC_SENSE0] |=> conv_a_pd_o
      == $past(conv_a_en))
    else $error("current sense alarm did not power down");
  no_event_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (alarm_i & alarm_sel) == '0 |=> conv_a_pd_o == '0)
    else $error("power down without a selected alarm");
  grp_b_pd_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    grp_b_event_i && conv_b_en != '0 |=> conv_b_pd_o != '0)
    else $error("group B converters not powered down");
  irq_sticky_a: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    ev_rise[APD_IRQ_CONV_A] |=> irq_stat[APD_IRQ_CONV_A])
    else $error("interrupt status missed an event");
  temp_pd_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    alarm_i[APD_ALM_TEMP] && src_q[APD_SRC_TEMP] ##1 conv_a_pd_o != '0);
  irq_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ev_rise[APD_IRQ_GRP_B] && irq_en[APD_IRQ_GRP_B] ##1 irq_o);
  clr_race_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    irq_clr[APD_IRQ_PIN_A] && ev_rise[APD_IRQ_PIN_A]);
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the auto-power-down control block.
`timescale 1ns/1ps
module tb;
  import apd_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata, rd, rnd;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [4:0] alarm = 5'h0;
  logic gb = 1'h0, pa = 1'h0;
  logic [3:0] pda, pdb, doff, trail, tconv;
  logic [3:0] r_clamp = 4'h0;
  logic [15:0] r_react = 16'hAAFF, r_src = 16'h0;
  int err_total = 0, n_checks = 0, seed = 84;
  int sb[5] = '{0, 1, 4, 5, 8};

  apd_ctrl apd_ctrl_i (
    .sys_clk_i(clk), .rst_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'h3), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .alarm_i(alarm),
    .grp_b_event_i(gb), .pin_a_event_i(pa),
    .conv_a_pd_o(pda), .conv_b_pd_o(pdb),
    .pin_drive_off_o(doff), .pin_tie_rail_o(trail),
    .pin_tie_conv_o(tconv), .irq_o(irq)
  );

  always #5 clk = ~clk;

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    logic ga, gw, done;
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    wdata <= {16'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk);
      ga = awready;
      gw = wready;
      done = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ga) awvalid <= 1'h0;
      if (gw) wvalid <= 1'h0;
    end while (!done);
    bready <= 1'h0;
  endtask

  task automatic rd_reg(input logic [9:0] idx);
    logic ga, done;
    @(posedge clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk);
      ga = arready;
      done = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge clk);
      if (ga) arvalid <= 1'h0;
    end while (!done);
    rready <= 1'h0;
  endtask

  function automatic logic evt(input logic [4:0] al, input logic [15:0] s);
    return |(al & {s[8], s[5], s[4], s[1], s[0]});
  endfunction

  // Result bits are tie to converter, tie to rail, drive off.
  function automatic logic [2:0] pin_exp(input logic [1:0] c,
                                         input logic cl, input logic ev);
    if (!ev || !c[1]) return 3'h0;
    if (c[0] && cl) return 3'h5;
    return 3'h3;
  endfunction

  task automatic check_out;
    logic ev;
    logic [3:0] ea, eb;
    logic [2:0] p;
    ev = evt(alarm, r_src);
    ea = ev ? r_react[3:0] : 4'h0;
    eb = gb ? r_react[7:4] : 4'h0;
    chk(pda, ea);
    chk(pdb, eb);
    for (int k = 0; k < 4; k++) begin
      p = pin_exp(r_react[8+2*k+:2], r_clamp[k], k < 2 ? pa : gb);
      chk({tconv[k], trail[k], doff[k]}, p);
    end
    rd_reg(APD_IDX_STATE);
    chk(rd, {23'h0, ev, eb, ea});
  endtask

  task automatic drive(input logic [4:0] al, input logic b, input logic a);
    @(posedge clk);
    alarm <= al;
    gb <= b;
    pa <= a;
    repeat (2) @(posedge clk);
    #1;
    check_out;
  endtask

  initial begin
    #100000;
    err_total++;
    complete_run;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    rd_reg(APD_IDX_REACT);
    chk(rd, 32'h0000AAFF);
    rd_reg(APD_IDX_SRC);
    chk(rd, 32'h0);
    chk(rs, APD_RESP_OKAY);
    rd_reg(APD_IDX_CLAMP);
    chk(rd, 32'h0);
    wr(10'h000, 16'hFFFF);
    chk(rs, APD_RESP_SLVERR);
    rd_reg(10'h3FF);
    chk(rd, 32'h0);
    chk(rs, APD_RESP_SLVERR);
    wr(APD_IDX_IRQ_EN, 16'h0002);
    drive(5'h0, 1'h1, 1'h0);
    chk(irq, 1'h1);
    drive(5'h0, 1'h0, 1'h1);
    rd_reg(APD_IDX_IRQ_STAT);
    chk(rd, 32'h6);
    wr(APD_IDX_IRQ_CLR, 16'h0002);
    chk(irq, 1'h0);
    wr(APD_IDX_IRQ_CLR, 16'h0007);
    for (int i = 0; i < 5; i++) begin
      r_src = 16'h0001 << sb[i];
      wr(APD_IDX_SRC, r_src);
      drive(5'h01 << i, 1'h0, 1'h0);
      drive(~(5'h01 << i), 1'h1, 1'h1);
    end
    r_react = 16'hFF50;
    r_clamp = 4'h5;
    wr(APD_IDX_REACT, r_react);
    wr(APD_IDX_CLAMP, {12'h0, r_clamp});
    drive(5'h1F, 1'h1, 1'h1);
    for (int n = 0; n < 40; n++) begin
      rnd = $random(seed);
      r_react = rnd[15:0];
      r_clamp = rnd[19:16];
      wr(APD_IDX_REACT, r_react);
      wr(APD_IDX_CLAMP, {12'h0, r_clamp});
      rnd = $random(seed);
      wr(APD_IDX_SRC, rnd[15:0]);
      rd_reg(APD_IDX_SRC);
      chk(rd, {16'h0, rnd[15:0] & APD_SRC_MASK});
      r_src = rnd[15:0] & APD_SRC_MASK;
      rd_reg(APD_IDX_REACT);
      chk(rd, {16'h0, r_react});
      drive(rnd[20:16], rnd[21], rnd[22]);
    end
    // A reset in mid-run must bring back the reset values.
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rd_reg(APD_IDX_REACT);
    chk(rd, 32'h0000AAFF);
    rd_reg(APD_IDX_SRC);
    chk(rd, 32'h0);
    complete_run;
  end
endmodule
